/* rtl/scs_consts.svh */
/*
 Constants for the shutter control sequencer: register offsets, field positions,
 reset values and timing. Assumes a 200 MHz clock and a 32-bit Avalon-MM slave.
*/
// Operation
// - normal mode opens the shutter for each exposure, closes it afterwards
// - always-closed mode keeps the shutter closed while selected
// - always-open mode keeps the shutter open for the whole experiment
// - open-before-trigger mode opens the shutter once ready for the start pulse
// - after opening, wait a 0..1000 ms opening delay in 1 ms steps (here in normal mode only; open-before-trigger exposes straight on the trigger)
// - after closing, wait a 0..1000 ms closing delay in 1 ms steps
// - shutter command leaves on a logic output to an external driver
// - the modes offered depend on the selected trigger response
// - an output with the shutter-open source is high while shutter commanded open
// - each trigger output has an inversion option making it active low
`ifndef SCS_CONSTS_SVH
`define SCS_CONSTS_SVH
`define SCS_ADDR_W 6
`define SCS_OFS_CTRL 6'h00
`define SCS_OFS_OPEN_DLY 6'h04
`define SCS_OFS_CLOSE_DLY 6'h08
`define SCS_OFS_EXP_TIME 6'h0C
`define SCS_OFS_STATUS 6'h10
`define SCS_OFS_CMD 6'h14
`define SCS_CTRL_MODE_LSB 0
`define SCS_CTRL_RESP_LSB 2
`define SCS_CTRL_SEL0_LSB 4
`define SCS_CTRL_INV0_BIT 7
`define SCS_CTRL_SEL1_LSB 8
`define SCS_CTRL_INV1_BIT 11
`define SCS_CTRL_RST 32'h0000_0000
`define SCS_CMD_START_BIT 0
`define SCS_CMD_ABORT_BIT 1
`define SCS_DLY_MAX_MS 10'h3E8
`define SCS_DLY_RST 10'h000
`define SCS_EXP_RST 10'h001
`define SCS_CLK_PERIOD_NS 5
`define SCS_MS_NS 1000000
`define SCS_MS_CYCLES (`SCS_MS_NS / `SCS_CLK_PERIOD_NS)
`endif

/* rtl/scs_ms_timer.sv */
/*
 Millisecond down-timer: loads a count of ms, pulses done when it has elapsed.
 Assumes one clock, synchronous active-low reset; load is a one-cycle pulse.
*/
`timescale 1ns/100ps
`include "scs_consts.svh"
module scs_ms_timer #(
    parameter int MS_CYCLES = `SCS_MS_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [9:0] ms_in,
    output logic done
);
    logic [31:0] pre_r, pre_nxt;
    logic [9:0] ms_r, ms_nxt;
    logic run_r, run_nxt;
    logic done_r, done_nxt;

    always_comb begin
        pre_nxt = pre_r;
        ms_nxt = ms_r;
        run_nxt = run_r;
        done_nxt = 1'b0;
        if (load) begin
            pre_nxt = 32'h0;
            ms_nxt = ms_in;
            run_nxt = 1'b1;
        end else if (run_r) begin
            if (ms_r == 10'h000) begin
                run_nxt = 1'b0;
                done_nxt = 1'b1;
            end else if (pre_r == 32'(MS_CYCLES - 1)) begin
                pre_nxt = 32'h0;
                ms_nxt = ms_r - 10'h001;
            end else begin
                pre_nxt = pre_r + 32'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pre_r <= 32'h0;
            ms_r <= 10'h000;
            run_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            ms_r <= ms_nxt;
            run_r <= run_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule

/* rtl/scs_pkg.sv */
/*
 Types of the shutter control sequencer.
 Assumes the constants header is included by each design file.
*/
package scs_pkg;
    typedef enum logic [1:0] {
        SCS_MODE_NORMAL,
        SCS_MODE_CLOSED,
        SCS_MODE_OPEN,
        SCS_MODE_PREARM
    } scs_mode_t;
    typedef enum logic [1:0] {
        SCS_RESP_NONE,
        SCS_RESP_READOUT,
        SCS_RESP_START,
        SCS_RESP_EXPOSE
    } scs_resp_t;
    typedef enum logic [2:0] {
        SCS_SRC_ACQUIRING,
        SCS_SRC_HIGH,
        SCS_SRC_EXPOSING,
        SCS_SRC_READOUT,
        SCS_SRC_SHUTTER,
        SCS_SRC_WAIT_TRIG,
        SCS_SRC_LOW,
        SCS_SRC_LOW2
    } scs_src_t;
    typedef enum {
        SCS_ST_IDLE,
        SCS_ST_ARM,
        SCS_ST_OPEN_WAIT,
        SCS_ST_EXPOSE,
        SCS_ST_CLOSE_WAIT,
        SCS_ST_READOUT
    } scs_state_t;
endpackage

/* rtl/scs_top.sv */
/*
 Shutter control sequencer: Avalon-MM register slave, acquisition sequence,
 shutter command and two configurable trigger outputs.
 Assumes a 200 MHz clk, synchronous active-low nrst, ext_trig from a pin.
*/
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "scs_consts.svh"
module scs_top #(
    parameter int MS_CYCLES = `SCS_MS_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [`SCS_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_trig,
    output logic shutter_open,
    output logic exposing,
    output logic readout_start,
    output logic [1:0] trig_out
);
    ////////////////////////////////////////////////////////////////////////////
    // register file
    logic [11:0] ctrl_r, ctrl_nxt;
    logic [9:0] open_dly_r, open_dly_nxt, close_dly_r, close_dly_nxt;
    logic [9:0] exp_r, exp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic start_cmd, abort_cmd;
    logic [31:0] status;
    logic acc, wr_go, rd_go;

    function automatic logic [9:0] clamp_ms(input logic [31:0] v);
        clamp_ms = (v > 32'(`SCS_DLY_MAX_MS)) ? `SCS_DLY_MAX_MS : v[9:0];
    endfunction

    assign acc = avs_read | avs_write;
    assign avs_waitrequest = acc & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ~ack_r;
    assign start_cmd = wr_go && avs_address == `SCS_OFS_CMD
                       && avs_writedata[`SCS_CMD_START_BIT];
    assign abort_cmd = wr_go && avs_address == `SCS_OFS_CMD
                       && avs_writedata[`SCS_CMD_ABORT_BIT];

    always_comb begin
        ctrl_nxt = ctrl_r;
        open_dly_nxt = open_dly_r;
        close_dly_nxt = close_dly_r;
        exp_nxt = exp_r;
        rdata_nxt = rdata_r;
        ack_nxt = acc & ~ack_r;
        if (wr_go) begin
            case (avs_address)
                `SCS_OFS_CTRL: ctrl_nxt = avs_writedata[11:0];
                `SCS_OFS_OPEN_DLY: open_dly_nxt = clamp_ms(avs_writedata);
                `SCS_OFS_CLOSE_DLY: close_dly_nxt = clamp_ms(avs_writedata);
                `SCS_OFS_EXP_TIME: exp_nxt = clamp_ms(avs_writedata);
                default: ;
            endcase
        end
        if (rd_go) begin
            case (avs_address)
                `SCS_OFS_CTRL: rdata_nxt = {20'h0, ctrl_r};
                `SCS_OFS_OPEN_DLY: rdata_nxt = {22'h0, open_dly_r};
                `SCS_OFS_CLOSE_DLY: rdata_nxt = {22'h0, close_dly_r};
                `SCS_OFS_EXP_TIME: rdata_nxt = {22'h0, exp_r};
                `SCS_OFS_STATUS: rdata_nxt = status;
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_r <= 12'(`SCS_CTRL_RST);
            open_dly_r <= `SCS_DLY_RST;
            close_dly_r <= `SCS_DLY_RST;
            exp_r <= `SCS_EXP_RST;
            rdata_r <= 32'h0;
            ack_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            open_dly_r <= open_dly_nxt;
            close_dly_r <= close_dly_nxt;
            exp_r <= exp_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end
    assign avs_readdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // trigger pin synchroniser and edge
    logic [2:0] sync_r, sync_nxt;
    logic trig_lvl_r, trig_lvl_nxt;
    logic trig_edge;

    assign trig_edge = (sync_r[1] == sync_r[2]) & sync_r[2] & ~trig_lvl_r;
    always_comb begin
        sync_nxt = {sync_r[1:0], ext_trig};
        trig_lvl_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : trig_lvl_r;
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync_r <= 3'h0;
            trig_lvl_r <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            trig_lvl_r <= trig_lvl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // acquisition sequence
    scs_pkg::scs_mode_t mode_sel, mode_eff;
    scs_pkg::scs_resp_t resp;
    scs_pkg::scs_state_t st_r, st_nxt;
    logic tmr_load, tmr_done;
    logic [9:0] tmr_ms;
    logic shut_r, shut_nxt, exp_o_r, exp_o_nxt, rd_o_r, rd_o_nxt;
    logic trig_ok;

    assign mode_sel = scs_pkg::scs_mode_t'(ctrl_r[`SCS_CTRL_MODE_LSB +: 2]);
    assign resp = scs_pkg::scs_resp_t'(ctrl_r[`SCS_CTRL_RESP_LSB +: 2]);
    // open-before-trigger needs an external start pulse to be waited for
    assign mode_eff = (mode_sel == scs_pkg::SCS_MODE_PREARM && resp == scs_pkg::SCS_RESP_NONE)
                      ? scs_pkg::SCS_MODE_NORMAL : mode_sel;
    assign trig_ok = (resp == scs_pkg::SCS_RESP_NONE) | trig_edge;

    always_comb begin
        st_nxt = st_r;
        tmr_load = 1'b0;
        tmr_ms = exp_r;
        rd_o_nxt = 1'b0;
        case (st_r)
            scs_pkg::SCS_ST_IDLE: begin
                if (start_cmd) begin
                    st_nxt = scs_pkg::SCS_ST_ARM;
                end
            end
            scs_pkg::SCS_ST_ARM: begin
                if (trig_ok) begin
                    tmr_load = 1'b1;
                    if (mode_eff == scs_pkg::SCS_MODE_NORMAL) begin
                        tmr_ms = open_dly_r;
                        st_nxt = scs_pkg::SCS_ST_OPEN_WAIT;
                    end else begin
                        st_nxt = scs_pkg::SCS_ST_EXPOSE;
                    end
                end
            end
            scs_pkg::SCS_ST_OPEN_WAIT: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    st_nxt = scs_pkg::SCS_ST_EXPOSE;
                end
            end
            scs_pkg::SCS_ST_EXPOSE: begin
                if (tmr_done) begin
                    if (mode_eff == scs_pkg::SCS_MODE_NORMAL
                        || mode_eff == scs_pkg::SCS_MODE_PREARM) begin
                        tmr_load = 1'b1;
                        tmr_ms = close_dly_r;
                        st_nxt = scs_pkg::SCS_ST_CLOSE_WAIT;
                    end else begin
                        st_nxt = scs_pkg::SCS_ST_READOUT;
                    end
                end
            end
            scs_pkg::SCS_ST_CLOSE_WAIT: begin
                if (tmr_done) begin
                    st_nxt = scs_pkg::SCS_ST_READOUT;
                end
            end
            scs_pkg::SCS_ST_READOUT: begin
                rd_o_nxt = 1'b1;
                st_nxt = scs_pkg::SCS_ST_IDLE;
            end
            default: st_nxt = scs_pkg::SCS_ST_IDLE;
        endcase
        if (abort_cmd) begin
            st_nxt = scs_pkg::SCS_ST_IDLE;
        end
        exp_o_nxt = (st_nxt == scs_pkg::SCS_ST_EXPOSE);
        case (mode_eff)
            scs_pkg::SCS_MODE_CLOSED: shut_nxt = 1'b0;
            scs_pkg::SCS_MODE_OPEN: shut_nxt = 1'b1;
            scs_pkg::SCS_MODE_PREARM: shut_nxt = st_nxt == scs_pkg::SCS_ST_ARM
                                   || st_nxt == scs_pkg::SCS_ST_EXPOSE;
            default: shut_nxt = st_nxt == scs_pkg::SCS_ST_OPEN_WAIT
                             || st_nxt == scs_pkg::SCS_ST_EXPOSE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= scs_pkg::SCS_ST_IDLE;
            shut_r <= 1'b0;
            exp_o_r <= 1'b0;
            rd_o_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            shut_r <= shut_nxt;
            exp_o_r <= exp_o_nxt;
            rd_o_r <= rd_o_nxt;
        end
    end

    scs_ms_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .clk(clk),
        .nrst(nrst),
        .load(tmr_load),
        .ms_in(tmr_ms),
        .done(tmr_done)
    );

    assign shutter_open = shut_r;
    assign exposing = exp_o_r;
    assign readout_start = rd_o_r;
    assign status = {24'h0, 1'b0, st_r[2:0], mode_eff, exp_o_r, shut_r};

    ////////////////////////////////////////////////////////////////////////////
    // trigger outputs
    logic [1:0] tout_r, tout_nxt;

    function automatic logic src_level(input logic [2:0] sel);
        case (scs_pkg::scs_src_t'(sel))
            scs_pkg::SCS_SRC_ACQUIRING: src_level = st_r != scs_pkg::SCS_ST_IDLE;
            scs_pkg::SCS_SRC_HIGH: src_level = 1'b1;
            scs_pkg::SCS_SRC_EXPOSING: src_level = exp_o_r;
            scs_pkg::SCS_SRC_READOUT: src_level = rd_o_r;
            scs_pkg::SCS_SRC_SHUTTER: src_level = shut_r;
            scs_pkg::SCS_SRC_WAIT_TRIG: src_level = st_r == scs_pkg::SCS_ST_ARM;
            default: src_level = 1'b0;
        endcase
    endfunction

    generate
        for (genvar i = 0; i < 2; i++) begin : g_tout
            always_comb begin
                tout_nxt[i] = src_level(ctrl_r[`SCS_CTRL_SEL0_LSB + 4*i +: 3])
                              ^ ctrl_r[`SCS_CTRL_INV0_BIT + 4*i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tout_r <= 2'h0;
        end else begin
            tout_r <= tout_nxt;
        end
    end
    assign trig_out = tout_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_closed_stays: assert property (@(posedge clk) disable iff (!nrst)
        mode_eff == scs_pkg::SCS_MODE_CLOSED |=> !shutter_open)
        else $error("shutter open in always-closed mode");
    a_open_stays: assert property (@(posedge clk) disable iff (!nrst)
        mode_eff == scs_pkg::SCS_MODE_OPEN |=> shutter_open)
        else $error("shutter closed in always-open mode");
    a_prearm_open: assert property (@(posedge clk) disable iff (!nrst)
        mode_eff == scs_pkg::SCS_MODE_PREARM && st_r == scs_pkg::SCS_ST_ARM
        && $past(st_r) == scs_pkg::SCS_ST_ARM |-> shutter_open)
        else $error("shutter not open while armed");
    a_normal_expose: assert property (@(posedge clk) disable iff (!nrst)
        mode_eff == scs_pkg::SCS_MODE_NORMAL && exposing |-> shutter_open)
        else $error("exposing with shutter closed");
    a_open_wait_first: assert property (@(posedge clk) disable iff (!nrst)
        $rose(st_r == scs_pkg::SCS_ST_EXPOSE) && mode_eff == scs_pkg::SCS_MODE_NORMAL
        |-> $past(st_r) == scs_pkg::SCS_ST_OPEN_WAIT)
        else $error("exposure began before opening delay");
    a_readout_after: assert property (@(posedge clk) disable iff (!nrst)
        readout_start |-> !shutter_open || mode_eff != scs_pkg::SCS_MODE_NORMAL)
        else $error("readout with shutter open in normal mode");
    a_delay_range: assert property (@(posedge clk) disable iff (!nrst)
        open_dly_r <= `SCS_DLY_MAX_MS && close_dly_r <= `SCS_DLY_MAX_MS)
        else $error("delay beyond limit");
    a_close_wait: assert property (@(posedge clk) disable iff (!nrst)
        st_r == scs_pkg::SCS_ST_CLOSE_WAIT |-> !shutter_open)
        else $error("shutter open during closing delay");
    a_tout_shutter: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_r[`SCS_CTRL_SEL0_LSB +: 3] == 3'h4 && !ctrl_r[`SCS_CTRL_INV0_BIT]
        && $stable(ctrl_r) |=> trig_out[0] == $past(shutter_open))
        else $error("shutter-open output mismatch");
    a_tout_invert: assert property (@(posedge clk) disable iff (!nrst)
        ctrl_r[`SCS_CTRL_SEL1_LSB +: 3] == 3'h1 && ctrl_r[`SCS_CTRL_INV1_BIT]
        && $stable(ctrl_r) |=> !trig_out[1])
        else $error("inverted high output not low");
    a_prearm_fallback: assert property (@(posedge clk) disable iff (!nrst)
        resp == scs_pkg::SCS_RESP_NONE |-> mode_eff != scs_pkg::SCS_MODE_PREARM)
        else $error("pre-arm mode without external trigger");
endmodule

/* verif/scs_shutter_drv.sv */
/*
 External shutter driver model: moves the shutter after a travel time.
 Assumes the command arrives on a trigger output set to the shutter source.
*/
`timescale 1ns/100ps
module scs_shutter_drv #(
    parameter int MOVE_CYC = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic cmd,
    output logic is_open,
    output int n_pulses
);
    int cnt_r;
    logic cmd_r;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_r <= 0;
            cmd_r <= 1'b0;
            is_open <= 1'b0;
            n_pulses <= 0;
        end else begin
            cmd_r <= cmd;
            if (cmd && !cmd_r) begin
                n_pulses <= n_pulses + 1;
            end
            // travel time before the blade follows the command
            if (cmd != is_open && cnt_r < MOVE_CYC) begin
                cnt_r <= cnt_r + 1;
            end else begin
                cnt_r <= 0;
                is_open <= cmd;
            end
        end
    end
endmodule

/* verif/shutter_control_sequencer_tb.sv */
/*
 Self-checking bench of the shutter sequencer: register access and shutter modes.
 Assumes scs_top with MS_CYCLES 10 and the shutter driver model on output 0.
*/
`timescale 1ns/100ps
`include "scs_consts.svh"
module shutter_control_sequencer_tb;
    localparam int MSC = 10;
    // both outputs on the shutter source, second one inverted
    localparam logic [31:0] OUTS = 32'h0000_0C40;
    logic clk;
    logic nrst;
    logic [5:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_trig;
    logic shutter_open;
    logic exposing;
    logic readout_start;
    logic [1:0] trig_out;
    logic drv_open;
    logic [1:0] pre;
    logic [31:0] q;
    int drv_pulses;
    int n_fail;
    int total_checks;
    int cyc;
    int n_op, n_ex, n_gap, n_dark, n_bad, n_tm, p0;

    scs_top #(.MS_CYCLES(MSC)) dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_trig(ext_trig), .shutter_open(shutter_open), .exposing(exposing),
        .readout_start(readout_start), .trig_out(trig_out));
    scs_shutter_drv #(.MOVE_CYC(3)) drv (.clk(clk), .nrst(nrst), .cmd(trig_out[0]),
        .is_open(drv_open), .n_pulses(drv_pulses));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // waitrequest is sampled at the rising edge only; data and write land there
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // start one acquisition and tally the outputs until the readout pulse
    task automatic run_acq(input logic [31:0] ctl, input int trig_at);
        int i;
        logic prev;
        logic seen;
        logic done;
        bus(1'b1, `SCS_OFS_CTRL, ctl);
        bus(1'b1, `SCS_OFS_CMD, 32'h0000_0001);
        {n_op, n_ex, n_gap, n_dark, n_bad, n_tm} = '0;
        pre = 2'b11;
        prev = shutter_open;
        seen = 1'b0;
        done = 1'b0;
        for (i = 0; i < 5000 && !done; i++) begin
            @(negedge clk);
            if (i == trig_at - 1) begin
                pre = {shutter_open, exposing};
            end
            n_op += int'(shutter_open);
            n_ex += int'(exposing);
            n_dark += int'(exposing && !drv_open);
            n_bad += int'(exposing && !shutter_open);
            n_gap += int'(seen && !shutter_open);
            n_tm += int'(trig_out !== {~prev, prev});
            seen |= shutter_open;
            prev = shutter_open;
            done = (readout_start === 1'b1);
            @(posedge clk);
            ext_trig <= (trig_at > 0 && i >= trig_at && i < trig_at + 4);
        end
        chk(done, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd_chk(`SCS_OFS_CTRL, 32'h0);
        rd_chk(`SCS_OFS_OPEN_DLY, 32'h0);
        rd_chk(`SCS_OFS_EXP_TIME, 32'h1);
        bus(1'b1, `SCS_OFS_OPEN_DLY, 32'h0000_07D0);
        rd_chk(`SCS_OFS_OPEN_DLY, 32'h0000_03E8);
        bus(1'b1, `SCS_OFS_CLOSE_DLY, 32'h0000_03E9);
        rd_chk(`SCS_OFS_CLOSE_DLY, 32'h0000_03E8);
        rd_chk(`SCS_OFS_CMD, 32'h0);
        rd_chk(6'h18, 32'h0);
        bus(1'b1, `SCS_OFS_OPEN_DLY, 32'h0000_0002);
        bus(1'b1, `SCS_OFS_CLOSE_DLY, 32'h0000_0003);
        // out0 always high, out1 always high but inverted
        bus(1'b1, `SCS_OFS_CTRL, 32'h0000_0910);
        @(negedge clk);
        chk(trig_out, 2'b01);
        @(posedge clk);
        // out0 acquiring while idle, out1 always low but inverted
        bus(1'b1, `SCS_OFS_CTRL, 32'h0000_0E00);
        @(negedge clk);
        chk(trig_out, 2'b10);
        @(posedge clk);
        $display("test regs done");
    endtask

    task automatic t_normal;
        p0 = drv_pulses;
        run_acq(OUTS, 0);
        chk(n_op, 2 * MSC + 2 + MSC + 2);
        chk(n_ex, MSC + 2);
        chk(n_gap, 3 * MSC + 4);
        chk(n_dark, 0);
        chk(n_tm, 0);
        chk(drv_pulses, p0 + 1);
        $display("test normal done");
    endtask

    task automatic t_fixed;
        p0 = drv_pulses;
        run_acq(OUTS | 32'h1, 0);
        chk(n_op, 0);
        chk(n_ex, MSC + 2);
        chk(drv_pulses, p0);
        chk(n_tm, 0);
        run_acq(OUTS | 32'h2, 0);
        chk(n_bad, 0);
        chk(n_ex, MSC + 2);
        chk(n_op >= n_ex, 1'b1);
        $display("test fixed modes done");
    endtask

    task automatic t_trig;
        int r;
        run_acq(OUTS | 32'h8 | 32'h3, 20);
        chk(pre, 2'b10);
        chk(n_ex, MSC + 2);
        chk(n_bad, 0);
        for (r = 1; r < 4; r++) begin
            run_acq(OUTS | 32'(r << 2), 20);
            chk(pre, 2'b00);
            chk(n_op > 0, 1'b1);
        end
        run_acq(OUTS | 32'h3, 0);
        chk(n_op, 2 * MSC + 2 + MSC + 2);
        $display("test trigger responses done");
    endtask

    task automatic t_abort;
        bus(1'b1, `SCS_OFS_CTRL, OUTS);
        bus(1'b1, `SCS_OFS_CMD, 32'h0000_0001);
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(shutter_open, 1'b1);
        @(posedge clk);
        bus(1'b1, `SCS_OFS_CMD, 32'h0000_0002);
        bus(1'b0, `SCS_OFS_STATUS, 32'h0);
        chk(q & 32'h0000_0071, 32'h0);
        @(negedge clk);
        chk(shutter_open, 1'b0);
        $display("test abort done");
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        nrst = 1'b0;
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        ext_trig = 1'b0;
        n_fail = 0;
        total_checks = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_regs();
        t_normal();
        t_fixed();
        t_trig();
        t_abort();
        finish_test();
    end
endmodule
